// >>> rtl/lcc_pkg.sv
// Constants and types shared by the logic capture clocking block
package lcc_pkg;
	localparam int CLK_NS = 100;
	localparam int POD_W = 17;
	localparam int CH_W = 34;
	localparam int NCLK = 6;
	localparam int NQ = 4;
	localparam int PA_W = 8;
	localparam int TAG_W = 16;
	localparam int DEPTH_FULL = 4096;
	localparam int DEPTH_DEEP_FULL = 1048576;
	localparam int AW_DEF = $clog2(DEPTH_FULL);
	localparam int AW_DEEP = $clog2(DEPTH_DEEP_FULL);
	localparam int T_CONV_FULL_NS = 4;
	localparam int T_CONV_HALF_NS = 2;
	localparam int T_TRANS_FULL_NS = 8;
	localparam int T_TRANS_HALF_NS = 4;
	localparam int T_GLITCH_NS = 8;
	localparam int CYC_CONV_FULL = (T_CONV_FULL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_CONV_HALF = (T_CONV_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_TRANS_FULL = (T_TRANS_FULL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_TRANS_HALF = (T_TRANS_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_GLITCH = (T_GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [PA_W-1:0] A_CTRL = 8'h00;
	localparam logic [PA_W-1:0] A_MARR = 8'h04;
	localparam logic [PA_W-1:0] A_SARR = 8'h08;
	localparam logic [PA_W-1:0] A_PERIOD = 8'h0c;
	localparam logic [PA_W-1:0] A_STATUS = 8'h10;
	localparam logic [PA_W-1:0] A_RDADDR = 8'h14;
	localparam logic [PA_W-1:0] A_RDLO = 8'h18;
	localparam logic [PA_W-1:0] A_RDHI = 8'h1c;
	localparam logic [PA_W-1:0] A_RDTAG = 8'h20;
	localparam logic [PA_W-1:0] A_CLKDATA = 8'h24;

	typedef enum logic [1:0] {
		ACQ_CONV = 2'b00,
		ACQ_TRANS = 2'b01,
		ACQ_GLITCH = 2'b10
	} lcc_acq_e;

	typedef enum logic [1:0] {
		ROLE_MASTER = 2'b00,
		ROLE_SLAVE = 2'b01,
		ROLE_DEMUX = 2'b10
	} lcc_role_e;

	typedef struct packed {
		logic [NCLK-1:0] rise;
		logic [NCLK-1:0] fall;
		logic [NQ-1:0]   qen;
		logic [NQ-1:0]   qlev;
		logic [1:0]      qor;
	} lcc_arr_s;

	typedef struct packed {
		lcc_role_e role1;
		lcc_role_e role0;
		logic      pod_sel;
		logic      half;
		lcc_acq_e  acq;
		logic      state_mode;
		logic      run;
	} lcc_ctrl_s;

	typedef struct packed {
		logic [NQ-1:0]   qual;
		logic [NCLK-1:0] clk;
		logic [CH_W-1:0] data;
	} lcc_pins_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} lcc_apb_rsp_s;
endpackage

// >>> rtl/lcc_clk_arr.sv
// Clock arrangement matcher built from two halves of clocks and qualifiers
`timescale 1ns/10ps
`default_nettype none
module lcc_clk_arr (
	input  wire logic [lcc_pkg::NCLK-1:0] rise_edges,
	input  wire logic [lcc_pkg::NCLK-1:0] fall_edges,
	input  wire logic [lcc_pkg::NQ-1:0]   qual,
	input  wire lcc_pkg::lcc_arr_s        cfg,
	output logic                          match
);
	import lcc_pkg::*;

	function automatic logic half_hit(
		input logic [2:0] re,
		input logic [2:0] fe,
		input logic [2:0] rsel,
		input logic [2:0] fsel,
		input logic [1:0] q,
		input logic [1:0] qen,
		input logic [1:0] qlev,
		input logic       qor
	);
		logic [1:0] ok;
		logic       qh;
		ok = ~(q ^ qlev) & qen;
		if (qen == 2'b00) begin
			qh = 1'b1;
		end else if (qor) begin
			qh = |ok;
		end else begin
			qh = (ok == qen);
		end
		return (|((re & rsel) | (fe & fsel))) & qh;
	endfunction

	always_comb begin
		match = half_hit(rise_edges[2:0], fall_edges[2:0], cfg.rise[2:0],
			cfg.fall[2:0], qual[1:0], cfg.qen[1:0], cfg.qlev[1:0], cfg.qor[0])
			| half_hit(rise_edges[5:3], fall_edges[5:3], cfg.rise[5:3],
			cfg.fall[5:3], qual[3:2], cfg.qen[3:2], cfg.qlev[3:2], cfg.qor[1]);
	end
endmodule
`default_nettype wire

// >>> rtl/lcc_capture.sv
// Acquisition front end: timing and state capture with APB register access
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module lcc_capture #(
	parameter int AW = lcc_pkg::AW_DEF
) (
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [lcc_pkg::PA_W-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [lcc_pkg::CH_W-1:0] probe_data,
	input  wire logic [lcc_pkg::NCLK-1:0] probe_clk,
	input  wire logic                     qualifier_a,
	input  wire logic                     qualifier_b,
	input  wire logic                     qualifier_c,
	input  wire logic                     qualifier_d,
	output logic                          capture_done
);
	import lcc_pkg::*;

	localparam logic [AW+1:0] DEP = {2'b01, {AW{1'b0}}};

	typedef struct packed {
		lcc_pins_s       s1;
		lcc_pins_s       s2;
		logic [NCLK-1:0] ckp;
		logic [CH_W-1:0] dp;
		lcc_ctrl_s       ctrl;
		lcc_arr_s        marr;
		lcc_arr_s        sarr;
		logic [15:0]     period;
		logic [AW:0]     rdaddr;
		logic            done;
		logic            first;
		logic [AW+1:0]   sidx;
		logic [15:0]     pcnt;
		logic [15:0]     tstamp;
		logic [CH_W-1:0] prev;
		logic [CH_W-1:0] gr;
		logic [CH_W-1:0] gf;
		logic [CH_W-1:0] slat;
		lcc_apb_rsp_s    rsp;
	} lcc_st_s;

	lcc_st_s         st_r;
	lcc_st_s         st_nxt;
	lcc_pins_s       pins_c;
	logic [NCLK-1:0] re_c;
	logic [NCLK-1:0] fe_c;
	logic [CH_W-1:0] dre;
	logic [CH_W-1:0] dfe;
	logic [CH_W-1:0] gedge;
	logic [CH_W-1:0] slat_eff;
	logic            m_hit;
	logic            s_hit;
	logic            tick;
	logic            full;
	logic            hpack;
	logic            chg;
	logic            acc;
	logic            rerr;
	logic            we_lo;
	logic            we_hi;
	logic            tag_we;
	logic [AW-1:0]   wa;
	logic [POD_W-1:0] wd_lo;
	logic [POD_W-1:0] wd_hi;
	logic [AW+1:0]   lim;
	logic [15:0]     minc;
	logic [15:0]     eff;
	logic [31:0]     rdat;

	// Capture memory: two pod-wide halves so half-channel conventional and transitional timing modes pack two samples
	logic [POD_W-1:0] mem_lo [2**AW];
	logic [POD_W-1:0] mem_hi [2**AW];
	logic [TAG_W-1:0] tag_mem [2**(AW+1)];

	function automatic logic [POD_W-1:0] pod_of(input logic [CH_W-1:0] v, input logic s);
		return s ? v[CH_W-1:POD_W] : v[POD_W-1:0];
	endfunction

	assign pins_c = '{qual: {qualifier_d, qualifier_c, qualifier_b, qualifier_a},
		clk: probe_clk, data: probe_data};
	assign re_c = st_r.s2.clk & ~st_r.ckp;
	assign fe_c = ~st_r.s2.clk & st_r.ckp;
	assign dre = st_r.s2.data & ~st_r.dp;
	assign dfe = ~st_r.s2.data & st_r.dp;
	// edge pair within one sample period
	assign gedge = (st_r.gr | dre) & (st_r.gf | dfe);
	assign slat_eff = s_hit ? st_r.s2.data : st_r.slat;

	lcc_clk_arr u_marr (
		.rise_edges (re_c),
		.fall_edges (fe_c),
		.qual       (st_r.s2.qual),
		.cfg        (st_r.marr),
		.match      (m_hit)
	);

	lcc_clk_arr u_sarr (
		.rise_edges (re_c),
		.fall_edges (fe_c),
		.qual       (st_r.s2.qual),
		.cfg        (st_r.sarr),
		.match      (s_hit)
	);

	always_comb begin
		st_nxt = st_r;
		we_lo = 1'b0;
		we_hi = 1'b0;
		tag_we = 1'b0;
		tick = 1'b0;
		rdat = 32'h0000_0000;
		rerr = 1'b0;
		// Pins pass two flip-flops before any logic looks at them
		st_nxt.s1 = pins_c;
		st_nxt.s2 = st_r.s1;
		st_nxt.ckp = st_r.s2.clk;
		st_nxt.dp = st_r.s2.data;

		// sample period never below its minimum for the acquisition mode
		case (st_r.ctrl.acq)
			ACQ_CONV: minc = st_r.ctrl.half ? 16'(CYC_CONV_HALF) : 16'(CYC_CONV_FULL);
			ACQ_TRANS: minc = st_r.ctrl.half ? 16'(CYC_TRANS_HALF) : 16'(CYC_TRANS_FULL);
			default: minc = 16'(CYC_GLITCH);
		endcase
		eff = (st_r.period > minc) ? st_r.period : minc;

		// depth scales with AW; deep variant sets AW larger
		hpack = st_r.ctrl.half & ~st_r.ctrl.state_mode & (st_r.ctrl.acq != ACQ_GLITCH);
		if (hpack) begin
			// two samples per word doubles depth
			lim = DEP << 1;
		end else if (!st_r.ctrl.state_mode && st_r.ctrl.acq == ACQ_GLITCH) begin
			// half the words, each data plus glitch
			lim = DEP >> 1;
		end else begin
			lim = DEP;
		end
		full = (st_r.sidx >= lim);
		wa = hpack ? st_r.sidx[AW:1] : st_r.sidx[AW-1:0];
		wd_lo = st_r.s2.data[POD_W-1:0];
		wd_hi = st_r.s2.data[CH_W-1:POD_W];

		// change test over the channels in use
		if (st_r.ctrl.half) begin
			chg = st_r.first | (pod_of(st_r.s2.data, st_r.ctrl.pod_sel)
				!= pod_of(st_r.prev, st_r.ctrl.pod_sel));
		end else begin
			chg = st_r.first | (st_r.s2.data != st_r.prev);
		end

		// internal sample clock in timing capture
		if (st_r.ctrl.run && !st_r.ctrl.state_mode) begin
			if (st_r.pcnt == 16'h0000) begin
				tick = 1'b1;
				st_nxt.pcnt = eff - 16'h0001;
			end else begin
				st_nxt.pcnt = st_r.pcnt - 16'h0001;
			end
		end else begin
			st_nxt.pcnt = 16'h0000;
		end

		// edge history restarts at each sample
		st_nxt.gr = tick ? dre : (st_r.gr | dre);
		st_nxt.gf = tick ? dfe : (st_r.gf | dfe);

		if (tick) begin
			st_nxt.prev = st_r.s2.data;
			st_nxt.tstamp = st_r.tstamp + 16'h0001;
			if (!full && (st_r.ctrl.acq != ACQ_TRANS || chg)) begin
				st_nxt.first = 1'b0;
				st_nxt.sidx = st_r.sidx + 1'b1;
				// time tag with every transitional sample
				tag_we = (st_r.ctrl.acq == ACQ_TRANS);
				if (st_r.ctrl.acq == ACQ_GLITCH) begin
					// data and glitch marker side by side
					wd_lo = pod_of(st_r.s2.data, st_r.ctrl.pod_sel);
					wd_hi = pod_of(gedge, st_r.ctrl.pod_sel);
					we_lo = 1'b1;
					we_hi = 1'b1;
				end else if (hpack) begin
					wd_lo = pod_of(st_r.s2.data, st_r.ctrl.pod_sel);
					wd_hi = wd_lo;
					we_lo = ~st_r.sidx[0];
					we_hi = st_r.sidx[0];
				end else begin
					we_lo = 1'b1;
					we_hi = 1'b1;
				end
			end
		end

		// slave latch keeps only the latest capture
		if (st_r.ctrl.state_mode && s_hit) begin
			st_nxt.slat = st_r.s2.data;
		end
		// master match writes both memory halves at once
		if (st_r.ctrl.run && st_r.ctrl.state_mode && m_hit && !full) begin
			we_lo = 1'b1;
			we_hi = 1'b1;
			st_nxt.sidx = st_r.sidx + 1'b1;
			if ((st_r.ctrl.pod_sel ? st_r.ctrl.role1 : st_r.ctrl.role0) == ROLE_DEMUX) begin
				// master group low, latched slave group high
				wd_lo = pod_of(st_r.s2.data, st_r.ctrl.pod_sel);
				wd_hi = pod_of(slat_eff, st_r.ctrl.pod_sel);
			end else begin
				wd_lo = (st_r.ctrl.role0 == ROLE_SLAVE) ? slat_eff[POD_W-1:0]
					: st_r.s2.data[POD_W-1:0];
				wd_hi = (st_r.ctrl.role1 == ROLE_SLAVE) ? slat_eff[CH_W-1:POD_W]
					: st_r.s2.data[CH_W-1:POD_W];
			end
		end

		if (st_r.ctrl.run && full) begin
			st_nxt.ctrl.run = 1'b0;
			st_nxt.done = 1'b1;
		end

		// One wait state: answer on the edge after the first access cycle
		acc = psel & penable & ~st_r.rsp.pready;
		case (paddr)
			A_CTRL: rdat = 32'(st_r.ctrl);
			A_MARR: rdat = 32'(st_r.marr);
			A_SARR: rdat = 32'(st_r.sarr);
			A_PERIOD: rdat = 32'(st_r.period);
			A_STATUS: rdat = 32'({st_r.done, st_r.ctrl.run, st_r.sidx});
			A_RDADDR: rdat = 32'(st_r.rdaddr);
			A_RDLO: rdat = 32'(mem_lo[st_r.rdaddr[AW-1:0]]);
			A_RDHI: rdat = 32'(mem_hi[st_r.rdaddr[AW-1:0]]);
			A_RDTAG: rdat = 32'(tag_mem[st_r.rdaddr]);
			// clocks outside both arrangements read as data
			A_CLKDATA: rdat = 32'(st_r.s2.clk & ~(st_r.marr.rise | st_r.marr.fall
				| st_r.sarr.rise | st_r.sarr.fall));
			default: rerr = 1'b1;
		endcase
		if (acc && pwrite && !rerr) begin
			case (paddr)
				A_CTRL: begin
					st_nxt.ctrl = lcc_ctrl_s'(pwdata[9:0]);
					// A new run restarts the capture state except the slave latch, even a done just raised
					if (pwdata[0]) begin
						st_nxt.sidx = '0;
						st_nxt.done = 1'b0;
						st_nxt.first = 1'b1;
						st_nxt.tstamp = 16'h0000;
						st_nxt.pcnt = 16'h0000;
						// Edges seen before the start must not mark the first sample
						st_nxt.gr = dre;
						st_nxt.gf = dfe;
					end
				end
				A_MARR: st_nxt.marr = lcc_arr_s'(pwdata[21:0]);
				A_SARR: st_nxt.sarr = lcc_arr_s'(pwdata[21:0]);
				A_PERIOD: st_nxt.period = pwdata[15:0];
				A_RDADDR: st_nxt.rdaddr = pwdata[AW:0];
				default: st_nxt.rdaddr = st_r.rdaddr;
			endcase
		end
		st_nxt.rsp.pready = acc;
		st_nxt.rsp.pslverr = acc & rerr;
		st_nxt.rsp.prdata = (acc && !pwrite) ? rdat : 32'h0000_0000;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (we_lo) begin
			mem_lo[wa] <= wd_lo;
		end
		if (we_hi) begin
			mem_hi[wa] <= wd_hi;
		end
		if (tag_we) begin
			tag_mem[st_r.sidx[AW:0]] <= st_r.tstamp;
		end
	end

	assign prdata = st_r.rsp.prdata;
	assign pready = st_r.rsp.pready;
	assign pslverr = st_r.rsp.pslverr;
	assign capture_done = st_r.done;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_conv_store: assert property (
		(!st_r.ctrl.state_mode && st_r.ctrl.acq == ACQ_CONV && tick && !full)
		|-> (we_lo || we_hi)) else $error("conventional sample not stored");
	a_trans_skip: assert property (
		(!st_r.ctrl.state_mode && st_r.ctrl.acq == ACQ_TRANS && tick && !chg)
		|-> !(we_lo || we_hi)) else $error("unchanged sample stored");
	a_trans_tag: assert property (
		(!st_r.ctrl.state_mode && st_r.ctrl.acq == ACQ_TRANS && we_lo)
		|-> tag_we) else $error("transitional sample without tag");
	a_master_store: assert property (
		(st_r.ctrl.state_mode && st_r.ctrl.run && m_hit && !full)
		|-> (we_lo && we_hi) ##1 (st_r.sidx == $past(st_r.sidx) + 1'b1))
		else $error("master match did not store");
	a_state_only_master: assert property (
		(st_r.ctrl.state_mode && !m_hit) |-> !(we_lo || we_hi))
		else $error("state store without master match");
	a_slave_latest: assert property (
		(st_r.ctrl.state_mode && s_hit) |=> (st_r.slat == $past(st_r.s2.data)))
		else $error("slave latch missed latest value");
	a_glitch_clear: assert property (
		tick |=> (st_r.gr == $past(dre)) && (st_r.gf == $past(dfe)))
		else $error("glitch history not cleared");
	a_apb_answer: assert property (
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	a_done_stop: assert property (
		(st_r.ctrl.run && full && !(psel && penable && pwrite)) |=> (st_r.done && !st_r.ctrl.run))
		else $error("capture did not stop when full");
	a_full_no_store: assert property (
		full |-> !(we_lo || we_hi)) else $error("store past memory limit");
	a_glitch_store: assert property (
		(!st_r.ctrl.state_mode && st_r.ctrl.acq == ACQ_GLITCH && tick && !full)
		|-> (we_lo && we_hi)) else $error("glitch sample not stored");
	a_half_alternate: assert property (
		(hpack && (we_lo || we_hi)) |-> (we_lo != we_hi))
		else $error("half-channel store hit both halves");

	c_state_store: cover property (st_r.ctrl.state_mode && m_hit && we_lo);
	c_trans_tag: cover property (tag_we);
	c_glitch_seen: cover property (tick && st_r.ctrl.acq == ACQ_GLITCH && |gedge);
	c_apb_write: cover property (acc && pwrite);
	c_half_pack: cover property (hpack && we_hi);
endmodule
`default_nettype wire

// >>> test/lcc_target_model.sv
// Target system model driving probe channels, clocks and qualifiers
`timescale 1ns/10ps
`default_nettype none
module lcc_target_model (
	input  wire logic                     core_clk,
	output logic      [lcc_pkg::CH_W-1:0] probe_data,
	output logic      [lcc_pkg::NCLK-1:0] probe_clk,
	output logic      [lcc_pkg::NQ-1:0]   qual
);
	import lcc_pkg::*;
	logic [NCLK-1:0] clk_base;
	initial begin
		probe_data = '0;
		probe_clk = '0;
		qual = '0;
		clk_base = '0;
	end
	task automatic put(input logic [CH_W-1:0] d, input logic [NQ-1:0] q);
		@(posedge core_clk);
		probe_data <= d;
		qual <= q;
	endtask
	// Steady levels on clocks used as data
	task automatic set_base(input logic [NCLK-1:0] b);
		@(posedge core_clk);
		clk_base = b;
		probe_clk <= b;
	endtask
	// Target clock pulse
	task automatic pulse(input logic [NCLK-1:0] m);
		@(posedge core_clk);
		probe_clk <= clk_base | m;
		repeat (4) @(posedge core_clk);
		probe_clk <= clk_base;
		repeat (4) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// >>> test/test_lcc_capture.sv
// Self-checking bench for the logic capture clocking block
`timescale 1ns/10ps
`default_nettype none
module test_lcc_capture;
	import lcc_pkg::*;
	localparam int AW_T = 4;
	typedef struct packed {
		logic [PA_W-1:0] a;
		logic [31:0]     d;
		logic [31:0]     x;
		logic            e;
	} lcc_row_s;
	logic            core_clk;
	logic            reset;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic [PA_W-1:0] paddr;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic            capture_done;
	logic [CH_W-1:0] pdata;
	logic [NCLK-1:0] pclk;
	logic [NQ-1:0]   tq;
	logic [31:0]     r;
	logic [31:0]     t0;
	logic            e;
	int              fails;
	int              checked;
	int              n;
	lcc_row_s        rows [5];

	lcc_capture #(.AW(AW_T)) i_dut (
		.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .probe_data(pdata), .probe_clk(pclk),
		.qualifier_a(tq[0]), .qualifier_b(tq[1]), .qualifier_c(tq[2]),
		.qualifier_d(tq[3]), .capture_done(capture_done)
	);
	lcc_target_model i_target (
		.core_clk(core_clk), .probe_data(pdata), .probe_clk(pclk), .qual(tq)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	// Setup, access until pready seen high, then release at that edge
	task automatic apb(input logic w, input logic [PA_W-1:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		// Values read right after the edge are those sampled at it
		@(posedge core_clk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge core_clk);
			k++;
		end
		if (pready !== 1'b1) begin
			fails++;
			stop_test();
		end else begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		fails = 0;
		checked = 0;
		rows[0] = '{A_MARR, 32'h002a_5a5a, 32'h002a_5a5a, 1'b0};
		rows[1] = '{A_SARR, 32'h0015_a5a5, 32'h0015_a5a5, 1'b0};
		rows[2] = '{A_PERIOD, 32'h0000_beef, 32'h0000_beef, 1'b0};
		rows[3] = '{A_STATUS, 32'h0000_ffff, 32'h0000_0000, 1'b0};
		rows[4] = '{8'h28, 32'h1234_5678, 32'h0000_0000, 1'b1};
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, A_CTRL, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, capture_done}, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk({31'h0, e}, {31'h0, rows[i].e});
			apb(1'b0, rows[i].a, 32'h0);
			chk(r, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		$display("test registers done");
		i_target.put({17'h0abcd, 17'h11234}, 4'h0);
		apb(1'b1, A_PERIOD, 32'h4);
		apb(1'b1, A_CTRL, 32'h1);
		n = 0;
		while (capture_done !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		chk({31'h0, (n >= 55 && n <= 70)}, 32'h1);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r, 32'h90);
		apb(1'b1, A_RDADDR, 32'h5);
		apb(1'b0, A_RDLO, 32'h0);
		chk(r, 32'h0001_1234);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h0000_abcd);
		$display("test conventional done");
		apb(1'b1, A_PERIOD, 32'h2);
		apb(1'b1, A_CTRL, 32'h5);
		idle(20);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r & 32'h3f, 32'h1);
		i_target.put({17'h0abcd, 17'h11235}, 4'h0);
		idle(20);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r & 32'h3f, 32'h2);
		apb(1'b1, A_RDADDR, 32'h0);
		apb(1'b0, A_RDTAG, 32'h0);
		t0 = r;
		apb(1'b1, A_RDADDR, 32'h1);
		apb(1'b0, A_RDTAG, 32'h0);
		chk({31'h0, (r > t0)}, 32'h1);
		$display("test transitional done");
		i_target.set_base(6'h02);
		apb(1'b1, A_MARR, 32'h0001_0044);
		apb(1'b1, A_SARR, 32'h0008_0000);
		apb(1'b1, A_CTRL, 32'h103);
		i_target.pulse(6'h01);
		idle(6);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r & 32'h3f, 32'h0);
		i_target.put({17'h00b01, 17'h0}, 4'h0);
		i_target.pulse(6'h08);
		i_target.put({17'h00b02, 17'h0}, 4'h0);
		i_target.pulse(6'h08);
		i_target.put({17'h00b03, 17'h0aaaa}, 4'h1);
		i_target.pulse(6'h01);
		idle(6);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r & 32'h3f, 32'h1);
		apb(1'b1, A_RDADDR, 32'h0);
		apb(1'b0, A_RDLO, 32'h0);
		chk(r, 32'h0000_aaaa);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h0000_0b02);
		apb(1'b0, A_CLKDATA, 32'h0);
		chk(r & 32'h3f, 32'h02);
		$display("test master slave done");
		apb(1'b1, A_MARR, 32'h0001_0000);
		apb(1'b1, A_CTRL, 32'h83);
		i_target.put({17'h0, 17'h05555}, 4'h0);
		i_target.pulse(6'h08);
		i_target.put({17'h0, 17'h06666}, 4'h0);
		i_target.pulse(6'h01);
		idle(6);
		apb(1'b1, A_RDADDR, 32'h0);
		apb(1'b0, A_RDLO, 32'h0);
		chk(r, 32'h0000_6666);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h0000_5555);
		$display("test demultiplex done");
		apb(1'b1, A_MARR, 32'h0014_03b8);
		apb(1'b1, A_SARR, 32'h0020_0000);
		apb(1'b1, A_CTRL, 32'h3);
		i_target.put({17'h00c01, 17'h00c02}, 4'h4);
		i_target.pulse(6'h10);
		i_target.pulse(6'h04);
		idle(6);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r & 32'h3f, 32'h0);
		i_target.put({17'h00c03, 17'h00c04}, 4'he);
		i_target.pulse(6'h20);
		i_target.pulse(6'h10);
		i_target.pulse(6'h04);
		idle(6);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r & 32'h3f, 32'h2);
		apb(1'b1, A_RDADDR, 32'h0);
		apb(1'b0, A_RDLO, 32'h0);
		chk(r, 32'h0000_0c04);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h0000_0c03);
		$display("test clock halves done");
		i_target.put({17'h0, 17'h00001}, 4'h0);
		apb(1'b1, A_PERIOD, 32'h14);
		apb(1'b1, A_CTRL, 32'h9);
		i_target.put({17'h0, 17'h00003}, 4'h0);
		idle(3);
		i_target.put({17'h0, 17'h00001}, 4'h0);
		idle(170);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r, 32'h88);
		apb(1'b1, A_RDADDR, 32'h1);
		apb(1'b0, A_RDLO, 32'h0);
		chk(r, 32'h1);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h2);
		apb(1'b1, A_RDADDR, 32'h0);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h0);
		$display("test glitch done");
		i_target.put({17'h1beef, 17'h00777}, 4'h0);
		apb(1'b1, A_PERIOD, 32'h2);
		apb(1'b1, A_CTRL, 32'h31);
		idle(80);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r, 32'ha0);
		apb(1'b1, A_RDADDR, 32'h0);
		apb(1'b0, A_RDLO, 32'h0);
		chk(r, 32'h0001_beef);
		apb(1'b0, A_RDHI, 32'h0);
		chk(r, 32'h0001_beef);
		$display("test half channel done");
		apb(1'b1, A_PERIOD, 32'h14);
		apb(1'b1, A_CTRL, 32'h1);
		idle(10);
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, A_CTRL, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, capture_done}, 32'h0);
		$display("test mid reset done");
		stop_test();
	end
endmodule
`default_nettype wire
